// [dv/prg_link_checker.sv]
// checker for the wires between programmer and device
// assumes both ends share clk_sys and meet on one prg_if
`timescale 1ns/1ps
module prg_link_checker
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic rst_n
);
	logic        sck_q;
	logic [15:0] nrise;
	logic [4:0]  lowrun;
	logic [15:0] sr;

	// ----
	// helper logic
	// ----
	// rises per session; cleared while the reset pin is high
	always_ff @(posedge clk_sys)
	begin
		sck_q <= sck;
		if (srst || rst_n)
			nrise <= 16'h0000;
		else if (sck && !sck_q)
			nrise <= nrise + 16'h0001;
	end
	// low run saturates, so long gaps never wrap
	always_ff @(posedge clk_sys)
	begin
		if (srst || sck)
			lowrun <= 5'h00;
		else if (lowrun != 5'h1F)
			lowrun <= lowrun + 5'h01;
	end
	// mosi history taken at each rise
	always_ff @(posedge clk_sys)
	begin
		if (sck && !sck_q)
			sr <= {sr[14:0], mosi};
	end

	// ----
	// properties
	// ----
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence s_high4;
		sck [*4] ##1 !sck;
	endsequence
	sequence s_low4;
		!sck [*4];
	endsequence
	sequence s_quiet8;
		!sck [*8];
	endsequence

	property p_idle;
		rst_n |-> !sck && !mosi;
	endproperty
	property p_mosi_hold;
		sck && $past(sck) |-> $stable(mosi);
	endproperty
	property p_high_len;
		$rose(sck) |-> s_high4;
	endproperty
	property p_low_len;
		$fell(sck) |-> s_low4;
	endproperty
	property p_entry;
		$fell(rst_n) |-> s_quiet8;
	endproperty
	// a long gap may only fall on a whole 32-bit frame
	property p_frame_gap;
		(lowrun == 5'h0C) |-> (nrise[4:0] == 5'h00);
	endproperty
	property p_enable_frame;
		(nrise == 16'h0010) |-> (sr == 16'hAC53);
	endproperty
	property p_miso_quiet;
		rst_n [*8] |-> !miso;
	endproperty

	a_idle: assert property (p_idle) else $error("link moves with reset pin high");
	a_mosi_hold: assert property (p_mosi_hold) else $error("mosi changed while sck high");
	a_high_len: assert property (p_high_len) else $error("sck high phase not four cycles");
	a_low_len: assert property (p_low_len) else $error("sck low phase too short");
	a_entry: assert property (p_entry) else $error("sck started right after reset pin fell");
	a_frame_gap: assert property (p_frame_gap) else $error("frame not 32 bits long");
	a_enable_frame: assert property (p_enable_frame) else $error("first frame is not enable");
	a_miso_quiet: assert property (p_miso_quiet) else $error("miso driven outside session");
endmodule

// [dv/tb_spi_serial_memory_programming.sv]
// bench: host and device joined across prg_if, user side driven here
// assumes rtl header, package, interface, fifo, host and device compiled first
`timescale 1ns/1ps
`include "prg_cfg.svh"
`define CHK(a, e) \
	begin tests_run++; if ((a) !== (e)) begin num_errors++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_spi_serial_memory_programming;
	import prg_pkg::*;
	// short waits keep the run small; erase must sweep all flash words
	localparam int FL = 200;
	localparam int EE = 300;
	localparam int ER = 8200;
	logic        clk_sys;
	logic        srst;
	logic        session;
	prg_word_t   cmd_data;
	logic        cmd_valid;
	logic        cmd_ready;
	logic [7:0]  rsp_data;
	logic        rsp_valid;
	logic        prog_mode;
	logic        busy;
	logic        normal_run;
	logic        active;
	int          num_errors;
	int          tests_run;
	int          bcur;
	int          blast;
	logic        full_seen;
	logic [31:0] seed;
	logic [31:0] mo_sr;
	logic [7:0]  mi_sr;
	logic [7:0]  rq[$];
	logic [15:0] pbuf[64];

	prg_if i_prg_if();
	prg_host #(.FLASH_CYC(FL), .EEPROM_CYC(EE), .ERASE_CYC(ER)) i_prg_host
	(
		.clk_sys(clk_sys), .srst(srst), .link(i_prg_if), .session(session), .cmd_data(cmd_data),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .active(active)
	);
	prg_dev #(.FLASH_CYC(FL), .EEPROM_CYC(EE), .ERASE_CYC(ER)) i_prg_dev
	(
		.clk_sys(clk_sys), .srst(srst), .link(i_prg_if), .prog_mode(prog_mode), .busy(busy),
		.normal_run(normal_run)
	);
	prg_link_checker i_prg_link_checker
	(
		.clk_sys(clk_sys), .srst(srst), .sck(i_prg_if.sck), .mosi(i_prg_if.mosi),
		.miso(i_prg_if.miso), .rst_n(i_prg_if.rst_n)
	);

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	// responses, busy length and fifo refusal, read where settled
	always @(negedge clk_sys)
	begin
		if (rsp_valid === 1'b1)
			rq.push_back(rsp_data);
		if (busy === 1'b1)
			bcur++;
		else if (bcur != 0)
		begin
			blast = bcur;
			bcur = 0;
		end
		if (cmd_valid === 1'b1 && cmd_ready === 1'b0)
			full_seen = 1'b1;
	end
	// wire capture: mosi at each rise, miso where the host takes it
	always @(posedge i_prg_if.sck) mo_sr = {mo_sr[30:0], i_prg_if.mosi};
	always @(negedge i_prg_if.sck) mi_sr = {mi_sr[6:0], i_prg_if.miso};

	// ----
	// stimulus helpers
	// ----
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic prg_word_t rdfl(logic [12:0] a, logic h);
		return {`PRG_OP_RDFLASH, h, `PRG_OP_LOW3, 3'h0, a, 8'h00};
	endfunction
	function automatic prg_word_t ldpg(logic [5:0] ix, logic h, logic [7:0] d);
		return {`PRG_OP_LOAD, h, `PRG_OP_LOW3, 10'h000, ix, d};
	endfunction
	function automatic prg_word_t wrpg(logic [6:0] p);
		return {`PRG_OP_WRPAGE, 3'h0, p, 14'h0000};
	endfunction
	function automatic prg_word_t rdee(logic [8:0] a);
		return {`PRG_OP_RDEE, 7'h00, a, 8'h00};
	endfunction
	function automatic prg_word_t wree(logic [8:0] a, logic [7:0] d);
		return {`PRG_OP_WREE, 7'h00, a, d};
	endfunction
	// valid stays up on return; caller lowers it or pushes again
	task automatic push(input prg_word_t w);
		cmd_data = w;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1)
			@(negedge clk_sys);
		@(negedge clk_sys);
	endtask
	task automatic wait_rsp(input int n);
		for (int k = 0; k < 20000 && rq.size() < n; k++)
			@(negedge clk_sys);
		// a response that never comes counts as a mismatch
		if (rq.size() < n)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%0h exp=%0h", $time, rq.size(), n);
		end
	endtask
	task automatic xfer(input prg_word_t w, output logic [7:0] d);
		push(w);
		cmd_valid = 1'b0;
		wait_rsp(1);
		d = rq.pop_front();
		`CHK(mo_sr, w)
		`CHK(mi_sr, d)
	endtask
	task automatic rd(input prg_word_t w, input logic [7:0] e);
		logic [7:0] d;
		xfer(w, d);
		`CHK(d, e)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----
	// main sequence
	// ----
	initial
	begin
		logic [7:0]  d;
		logic [31:0] r;
		logic [6:0]  pg;
		logic [8:0]  ea;
		logic [7:0]  e1ff;
		logic [5:0]  ix[4];
		prg_word_t   rw[9];
		seed = 32'h0000FEFF;
		srst = 1'b1;
		session = 1'b0;
		cmd_valid = 1'b0;
		cmd_data = 32'h00000000;
		num_errors = 0;
		tests_run = 0;
		bcur = 0;
		blast = 0;
		full_seen = 1'b0;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		srst = 1'b0;
		repeat (4) @(negedge clk_sys);
		`CHK(normal_run, 1'b1)
		session = 1'b1;
		repeat (8) @(negedge clk_sys);
		`CHK(normal_run, 1'b0)
		`CHK(active, 1'b1)
		`CHK(prog_mode, 1'b0)
		xfer(wree(9'h1FF, 8'h5A), d);
		`CHK(prog_mode, 1'b1)
		rd(rdee(9'h1FF), 8'h5A);
		`CHK(blast, EE)
		// erase, then stuff the fifo while the host sits out the erase wait
		xfer({`PRG_OP_ENABLE, `PRG_OP_ERASE2, 21'h000000}, d);
		rw[0] = rdee(9'h1FF);
		for (int i = 1; i < 9; i++)
		begin
			r = xs();
			rw[i] = r[31] ? rdee(r[8:0]) : rdfl(r[12:0], r[30]);
		end
		foreach (rw[i])
			push(rw[i]);
		cmd_valid = 1'b0;
		`CHK(full_seen, 1'b1)
		wait_rsp(9);
		foreach (rw[i])
		begin
			d = rq.pop_front();
			`CHK(d, `PRG_FILL)
		end
		`CHK(blast, ER)
		// two pages: the top page, then a random one; edge indices included
		for (int p = 0; p < 2; p++)
		begin
			r = xs();
			pg = (p == 0) ? 7'h7F : r[6:0];
			ix = '{6'h00, 6'h3F, r[13:8], r[21:16]};
			foreach (ix[i])
			begin
				r = xs();
				pbuf[ix[i]] = r[15:0];
				xfer(ldpg(ix[i], 1'b0, r[7:0]), d);
				xfer(ldpg(ix[i], 1'b1, r[15:8]), d);
			end
			xfer(wrpg(pg), d);
			foreach (ix[i])
			begin
				rd(rdfl({pg, ix[i]}, 1'b0), pbuf[ix[i]][7:0]);
				rd(rdfl({pg, ix[i]}, 1'b1), pbuf[ix[i]][15:8]);
			end
			`CHK(blast, FL)
		end
		// eeprom bytes, first at address zero, others random; track the top byte
		e1ff = `PRG_FILL;
		for (int i = 0; i < 4; i++)
		begin
			r = xs();
			ea = (i == 0) ? 9'h000 : r[8:0];
			if (ea == 9'h1FF)
				e1ff = r[23:16];
			xfer(wree(ea, r[23:16]), d);
			rd(rdee(ea), r[23:16]);
		end
		session = 1'b0;
		repeat (8) @(negedge clk_sys);
		`CHK(prog_mode, 1'b0)
		`CHK(normal_run, 1'b1)
		`CHK(active, 1'b0)
		// second session: enable again, contents kept
		session = 1'b1;
		rd(rdee(9'h1FF), e1ff);
		session = 1'b0;
		tally_and_finish();
	end

	// roughly four times the expected run length
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		num_errors++;
		$display("[FAIL] t=%0t got=%0h exp=%0h", $time, 0, 1);
		tally_and_finish();
	end
endmodule

// [rtl/prg_cfg.svh]
// constants for the serial programming link: opcodes, sizes, timing
// assumes a 25 MHz system clock on both ends of the link
`ifndef PRG_CFG_SVH
`define PRG_CFG_SVH

// system clock period
`define PRG_CLK_NS          40
// minimum waits, in ns
`define PRG_FLASH_WAIT_NS   4500000
`define PRG_EEPROM_WAIT_NS  9000000
`define PRG_ERASE_WAIT_NS   9000000
// instruction bytes and opcode fields
`define PRG_OP_ENABLE       8'hAC
`define PRG_OP_ENABLE2      8'h53
`define PRG_OP_ERASE2       3'h4
`define PRG_OP_LOAD         4'h4
`define PRG_OP_WRPAGE       8'h4C
`define PRG_OP_RDFLASH      4'h2
`define PRG_OP_RDEE         8'hA0
`define PRG_OP_WREE         8'hC0
`define PRG_OP_LOW3         3'h0
// polled and erased value
`define PRG_FILL            8'hFF
`define PRG_FILL_W          16'hFFFF
// frame layout: bit counts of rising edges
`define PRG_LAST_BIT        6'h1F
`define PRG_RD_BIT          6'h17
`define PRG_OUT_BIT         6'h18
// memory geometry
`define PRG_FL_WORDS        8192
`define PRG_EE_BYTES        512
`define PRG_PAGE_WORDS      64
`define PRG_SWP_MAX         13'h1FFF
`define PRG_TMR_W           18
// host link timing
`define PRG_HALF_CYC        2'h3
`define PRG_ENTRY_CYC       6'h20
`define PRG_WAIT_MARGIN     18'h10

`endif

// [rtl/prg_dev.sv]
// device end: serial programming slave over flash and eeprom
// assumes link pins are asynchronous and are sampled on clk_sys
`timescale 1ns/1ps
`include "prg_cfg.svh"

// Functional notes
// - programming only while reset pin low
// - clock and data in from programmer, data out
// - program and erase ignored until enable
// - page buffer loaded byte-wise by 6-bit index
// - programmer loads low byte before high
// - write-page commits buffer to 7-bit page
// - programmer waits 4.5 ms per page unpolled
// - no port access during flash write
// - eeprom byte write, auto-erase first
// - programmer waits 9.0 ms per eeprom byte
// - read shifts stored content out
// - reset high leaves programming mode
// - no flash polling for ff value
// - busy eeprom address reads ff
// - eeprom ff rewrite needs fixed wait
// - programmer waits 9.0 ms after erase
// - enable is ac 53 then two bytes
// - chip erase clears eeprom and flash
// - write-page opcode 4c, page from bytes 2-3
module prg_dev #(
	parameter int unsigned FLASH_CYC  = (`PRG_FLASH_WAIT_NS + `PRG_CLK_NS - 1) / `PRG_CLK_NS,
	parameter int unsigned EEPROM_CYC = (`PRG_EEPROM_WAIT_NS + `PRG_CLK_NS - 1) / `PRG_CLK_NS,
	parameter int unsigned ERASE_CYC  = (`PRG_ERASE_WAIT_NS + `PRG_CLK_NS - 1) / `PRG_CLK_NS
) (
	input  wire logic clk_sys,
	input  wire logic srst,
	prg_if.dev        link,
	output logic      prog_mode,
	output logic      busy,
	output logic      normal_run
);
	import prg_pkg::*;

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [15:0] flash    [`PRG_FL_WORDS];
	logic [7:0]  eeprom   [`PRG_EE_BYTES];
	logic [15:0] page_buf [`PRG_PAGE_WORDS];

	logic        sck_m;
	logic        sck_q;
	logic        sck_d;
	logic        mosi_m;
	logic        mosi_q;
	logic        rst_m;
	logic        rst_q;
	logic        rise;
	logic        fall;
	logic [5:0]  cnt;
	prg_word_t   sr;
	prg_word_t   word;
	logic [23:0] head;
	logic        cmd_done;
	logic        rd_load;
	logic [7:0]  out_sr;
	logic [7:0]  rd_byte;
	logic [12:0] rd_faddr;
	logic [8:0]  rd_eaddr;
	logic [15:0] rd_word;
	logic        prog_en;
	logic        allow;
	prg_op_e     op;
	prg_tmr_t    tmr;
	logic [6:0]  pg;
	logic [8:0]  ee_addr;
	logic [12:0] swp;
	logic        is_enable;
	logic        is_erase;
	logic        is_load;
	logic        is_wrpage;
	logic        is_wree;

	// ------------------------------------------------------------
	// pin synchronisers and edge detect
	// ------------------------------------------------------------
	// two flops per pin, a third on sck; edges are found only past the second
	always_ff @(posedge clk_sys)
	begin
		sck_m  <= link.sck;
		sck_q  <= sck_m;
		sck_d  <= sck_q;
		mosi_m <= link.mosi;
		mosi_q <= mosi_m;
		rst_m  <= link.rst_n;
		rst_q  <= rst_m;
	end

	assign rise       = sck_q & ~sck_d;
	assign fall       = ~sck_q & sck_d;
	assign normal_run = rst_q & ~srst;
	assign prog_mode  = prog_en;
	assign busy       = op != PRG_OP_IDLE;

	// ------------------------------------------------------------
	// frame shifter
	// ------------------------------------------------------------
	// the frame is reset whenever the reset pin is high
	always_ff @(posedge clk_sys)
	begin
		if (srst | rst_q)
		begin
			cnt <= '0;
			sr  <= '0;
		end
		else if (rise)
		begin
			sr  <= {sr[30:0], mosi_q};
			cnt <= (cnt == `PRG_LAST_BIT) ? 6'h00 : cnt + 1'b1;
		end
	end

	assign word     = {sr[30:0], mosi_q};
	assign head     = {sr[22:0], mosi_q};
	assign cmd_done = rise & (cnt == `PRG_LAST_BIT) & ~rst_q & ~srst;
	assign rd_load  = rise & (cnt == `PRG_RD_BIT) & ~rst_q & ~srst;

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	// the address is complete after byte three; reply in byte four
	always_comb
	begin
		rd_faddr = {head[12:8], head[7:0]};
		rd_eaddr = {head[8], head[7:0]};
		rd_word  = flash[rd_faddr];
		rd_byte  = '0;
		if (head[23:20] == `PRG_OP_RDFLASH && head[18:16] == `PRG_OP_LOW3)
		begin
			rd_byte = head[19] ? rd_word[15:8] : rd_word[7:0];
			if (op == PRG_OP_ERASE || (op == PRG_OP_FLASH && rd_faddr[12:6] == pg))
				rd_byte = `PRG_FILL;
		end
		else if (head[23:16] == `PRG_OP_RDEE)
		begin
			rd_byte = eeprom[rd_eaddr];
			if (op == PRG_OP_ERASE || (op == PRG_OP_EEPROM && rd_eaddr == ee_addr))
				rd_byte = `PRG_FILL;
		end
	end

	// output shifter: loaded on a rise, moved on the falls of byte four
	always_ff @(posedge clk_sys)
	begin
		if (srst | rst_q)
			out_sr <= '0;
		else if (rd_load)
			out_sr <= rd_byte;
		else if (fall && cnt > `PRG_OUT_BIT)
			out_sr <= {out_sr[6:0], 1'b0};
		else if (fall && cnt == '0)
			out_sr <= '0;
	end

	assign link.miso = out_sr[7];

	// ------------------------------------------------------------
	// instruction decode
	// ------------------------------------------------------------
	assign is_enable = word[31:24] == `PRG_OP_ENABLE && word[23:16] == `PRG_OP_ENABLE2;
	assign is_erase  = word[31:24] == `PRG_OP_ENABLE && word[23:21] == `PRG_OP_ERASE2;
	assign is_load   = word[31:28] == `PRG_OP_LOAD && word[26:24] == `PRG_OP_LOW3;
	assign is_wrpage = word[31:24] == `PRG_OP_WRPAGE;
	assign is_wree   = word[31:24] == `PRG_OP_WREE;
	// a write while busy is dropped rather than corrupting the one in flight
	assign allow     = cmd_done & prog_en & ~busy;

	// enable latch, cleared by the reset pin going high
	always_ff @(posedge clk_sys)
	begin
		if (srst | rst_q)
			prog_en <= 1'b0;
		else if (cmd_done & is_enable)
			prog_en <= 1'b1;
	end

	// page buffer: one byte lane per load
	always_ff @(posedge clk_sys)
	begin
		if (allow & is_load)
		begin
			if (word[27])
				page_buf[word[13:8]][15:8] <= word[7:0];
			else
				page_buf[word[13:8]][7:0] <= word[7:0];
		end
	end

	// ------------------------------------------------------------
	// operation timer
	// ------------------------------------------------------------
	// busy lasts the full minimum wait, so polling matches fixed waits
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			op      <= PRG_OP_IDLE;
			tmr     <= '0;
			pg      <= '0;
			ee_addr <= '0;
		end
		else if (busy)
		begin
			tmr <= tmr - 1'b1;
			if (tmr == prg_tmr_t'(1))
				op <= PRG_OP_IDLE;
		end
		else if (allow & is_wrpage)
		begin
			op  <= PRG_OP_FLASH;
			pg  <= {word[20:16], word[15:14]};
			tmr <= prg_tmr_t'(FLASH_CYC);
		end
		else if (allow & is_wree)
		begin
			op      <= PRG_OP_EEPROM;
			ee_addr <= {word[16], word[15:8]};
			tmr     <= prg_tmr_t'(EEPROM_CYC);
		end
		else if (allow & is_erase)
		begin
			op  <= PRG_OP_ERASE;
			tmr <= prg_tmr_t'(ERASE_CYC);
		end
	end

	// sweep address; saturates, the timer ends the operation
	always_ff @(posedge clk_sys)
	begin
		if (srst | ~busy)
			swp <= '0;
		else if (swp != `PRG_SWP_MAX)
			swp <= swp + 1'b1;
	end

	// ------------------------------------------------------------
	// array updates
	// ------------------------------------------------------------
	// whole page copied during busy; reads of that page are masked meanwhile
	always_ff @(posedge clk_sys)
	begin
		if (op == PRG_OP_FLASH && swp < 13'(`PRG_PAGE_WORDS))
			flash[{pg, swp[5:0]}] <= page_buf[swp[5:0]];
		else if (op == PRG_OP_ERASE)
			flash[swp] <= `PRG_FILL_W;
	end

	// overwrite replaces the old byte, which is the erase-then-write
	always_ff @(posedge clk_sys)
	begin
		if (allow & is_wree)
			eeprom[{word[16], word[15:8]}] <= word[7:0];
		else if (op == PRG_OP_ERASE && swp < 13'(`PRG_EE_BYTES))
			eeprom[swp[8:0]] <= `PRG_FILL;
	end
endmodule

// [rtl/prg_fifo.sv]
// small synchronous fifo with valid/ready on both sides
// assumes DEPTH is a power of two
`timescale 1ns/1ps
module prg_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;

	// extra pointer bit tells full from empty
	assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
	assign out_valid = wr_ptr != rd_ptr;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	// storage
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	// pointers
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule

// [rtl/prg_host.sv]
// programmer end: drives clock, data in and reset of the device
// assumes user commands are whole 32-bit instructions, msb byte first
`timescale 1ns/1ps
`include "prg_cfg.svh"
module prg_host #(
	parameter int unsigned FLASH_CYC  = (`PRG_FLASH_WAIT_NS + `PRG_CLK_NS - 1) / `PRG_CLK_NS,
	parameter int unsigned EEPROM_CYC = (`PRG_EEPROM_WAIT_NS + `PRG_CLK_NS - 1) / `PRG_CLK_NS,
	parameter int unsigned ERASE_CYC  = (`PRG_ERASE_WAIT_NS + `PRG_CLK_NS - 1) / `PRG_CLK_NS
) (
	input  wire logic          clk_sys,
	input  wire logic          srst,
	prg_if.prg                 link,
	input  wire logic          session,
	input  wire prg_pkg::prg_word_t cmd_data,
	input  wire logic          cmd_valid,
	output logic               cmd_ready,
	output logic [7:0]         rsp_data,
	output logic               rsp_valid,
	output logic               active
);
	import prg_pkg::*;

	prg_hst_e   state;
	prg_word_t  f_data;
	logic       f_valid;
	logic       f_pop;
	prg_word_t  sr;
	logic [7:0] rx;
	logic [5:0] nbit;
	logic [5:0] ecnt;
	prg_tmr_t   wcnt;
	prg_tmr_t   next_wait;
	logic [1:0] div;
	logic       tick;
	logic       miso_m;
	logic       miso_q;
	logic       user_cmd;

	// command queue; stalls the user only when all 8 entries are full
	prg_fifo #(.WIDTH(32), .DEPTH(8)) i_prg_fifo
	(
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_data   (cmd_data),
		.in_valid  (cmd_valid),
		.in_ready  (cmd_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_pop)
	);

	assign f_pop  = (state == PRG_H_FETCH) & f_valid;
	assign tick   = div == `PRG_HALF_CYC;
	assign active = state != PRG_H_IDLE;

	// data out of the device is asynchronous to us
	always_ff @(posedge clk_sys)
	begin
		miso_m <= link.miso;
		miso_q <= miso_m;
	end

	// half-period divider for the serial clock
	always_ff @(posedge clk_sys)
	begin
		if (srst | (state == PRG_H_IDLE))
			div <= '0;
		else
			div <= div + 1'b1;
	end

	// no polling: write-page, eeprom write and erase wait the full minimum plus margin; others none
	always_comb
	begin
		next_wait = '0;
		if (f_data[31:24] == `PRG_OP_WRPAGE)
			next_wait = prg_tmr_t'(FLASH_CYC) + `PRG_WAIT_MARGIN;
		else if (f_data[31:24] == `PRG_OP_WREE)
			next_wait = prg_tmr_t'(EEPROM_CYC) + `PRG_WAIT_MARGIN;
		else if (f_data[31:24] == `PRG_OP_ENABLE && f_data[23:21] == `PRG_OP_ERASE2)
			next_wait = prg_tmr_t'(ERASE_CYC) + `PRG_WAIT_MARGIN;
	end

	// sequencer; fifo order keeps low byte before high byte
	always_ff @(posedge clk_sys)
	begin
		rsp_valid <= 1'b0;
		if (srst | ~session)
		begin
			state      <= PRG_H_IDLE;
			link.rst_n <= 1'b1;
			link.sck   <= 1'b0;
			link.mosi  <= 1'b0;
			sr         <= '0;
			rx         <= '0;
			nbit       <= '0;
			ecnt       <= '0;
			wcnt       <= '0;
			user_cmd   <= 1'b0;
			rsp_data   <= '0;
		end
		else
		begin
			unique case (state)
				PRG_H_IDLE:
				begin
					link.rst_n <= 1'b0;
					ecnt       <= '0;
					state      <= PRG_H_ENTRY;
				end
				PRG_H_ENTRY:
				begin
					ecnt <= ecnt + 1'b1;
					if (ecnt == `PRG_ENTRY_CYC)
					begin
						sr        <= {`PRG_OP_ENABLE, `PRG_OP_ENABLE2, 16'h0000};
						link.mosi <= 1'(`PRG_OP_ENABLE >> 7);
						user_cmd  <= 1'b0;
						wcnt      <= `PRG_WAIT_MARGIN;
						nbit      <= '0;
						state     <= PRG_H_LOW;
					end
				end
				PRG_H_FETCH:
				begin
					if (f_valid)
					begin
						sr        <= f_data;
						link.mosi <= f_data[31];
						wcnt      <= next_wait;
						user_cmd  <= 1'b1;
						nbit      <= '0;
						state     <= PRG_H_LOW;
					end
				end
				PRG_H_LOW:
				begin
					if (tick)
					begin
						link.sck <= 1'b1;
						state    <= PRG_H_HIGH;
					end
				end
				PRG_H_HIGH:
				begin
					// sample late in the high phase, clear of the device's update
					if (tick)
					begin
						rx        <= {rx[6:0], miso_q};
						link.sck  <= 1'b0;
						sr        <= {sr[30:0], 1'b0};
						link.mosi <= sr[30];
						nbit      <= nbit + 1'b1;
						if (nbit == `PRG_LAST_BIT)
						begin
							rsp_data  <= {rx[6:0], miso_q};
							rsp_valid <= user_cmd;
							state     <= PRG_H_WAIT;
						end
						else
							state <= PRG_H_LOW;
					end
				end
				PRG_H_WAIT:
				begin
					if (wcnt == '0)
						state <= PRG_H_FETCH;
					else
						wcnt <= wcnt - 1'b1;
				end
				default:
					state <= PRG_H_IDLE;
			endcase
		end
	end
endmodule

// [rtl/prg_if.sv]
// serial programming link between programmer and device
// assumes the bench joins both modports; all pins one-way
`timescale 1ns/1ps
interface prg_if;
	logic sck;
	logic mosi;
	logic miso;
	logic rst_n;

	modport dev
	(
		input  sck,
		input  mosi,
		input  rst_n,
		output miso
	);
	modport prg
	(
		output sck,
		output mosi,
		output rst_n,
		input  miso
	);
endinterface

// [rtl/prg_pkg.sv]
// types shared by both ends of the serial programming link
// assumes prg_cfg.svh for all numeric constants
package prg_pkg;
	typedef logic [31:0] prg_word_t;
	typedef logic [17:0] prg_tmr_t;

	// operation running inside the device
	typedef enum logic [1:0]
	{
		PRG_OP_IDLE   = 2'b00,
		PRG_OP_FLASH  = 2'b01,
		PRG_OP_EEPROM = 2'b10,
		PRG_OP_ERASE  = 2'b11
	} prg_op_e;

	// programmer sequencing
	typedef enum logic [2:0]
	{
		PRG_H_IDLE  = 3'b000,
		PRG_H_ENTRY = 3'b001,
		PRG_H_FETCH = 3'b010,
		PRG_H_LOW   = 3'b011,
		PRG_H_HIGH  = 3'b100,
		PRG_H_WAIT  = 3'b101
	} prg_hst_e;
endpackage
